// file: rtl/gcp_core.sv
// Purpose: Compensation arithmetic, power modes and config-memory unlock
// Assumes: Core clock 20 MHz; measurements arrive as same-domain inputs
// Notes: Communication lines and supply flags are pins, synchronised here
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "gcp_map.svh"
module gcp_core
	import gcp_pkg::*;
#(
	parameter int unsigned LOW_HOLD_CYC = `GCP_LOW_HOLD_CYC,
	parameter longint unsigned WAKE_CYC = `GCP_WAKE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] comm_line,
	input wire logic supply_above_por,
	input wire logic backup_supply_input,
	input wire logic [15:0] average_current,
	input wire logic [15:0] temp_kelvin,
	input wire logic [15:0] nominal_available_charge,
	input wire logic [15:0] compensation_at_last_learn,
	input wire logic activity_above_filter,
	input wire logic full_reset_req,
	output logic [15:0] max_load_current,
	output logic [15:0] discharge_compensated_capacity,
	output logic [15:0] temp_compensated_capacity,
	output logic gauging_enable,
	output logic full_reset_pulse,
	output logic retain_gauge_ram,
	output logic program_unlocked,
	output logic [3:0] power_mode
);
	// -------------------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------------------
	// Saturating subtract used by every clamped term
	function automatic logic [31:0] gcp_clamp_sub(input logic [31:0] a, input logic [31:0] b);
		gcp_clamp_sub = (a > b) ? a - b : 32'h0000_0000;
	endfunction : gcp_clamp_sub

	// -------------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------------
	logic [7:0] mode_q;
	logic [7:0] unlock_q;
	logic [7:0] initial_capacity_byte_q;
	logic [7:0] pack_configuration_q;
	logic [7:0] initial_max_load_q;
	logic [7:0] discharge_rate_coeffs_q;
	logic [7:0] temperature_coeffs_q;
	logic [7:0] dmfsd_q;
	logic ship_armed_q;
	logic unlocked;

	// Unlock key match; cleared by any other value
	assign unlocked = (unlock_q == `GCP_UNLOCK_KEY);
	assign program_unlocked = unlocked;

	// Writable registers; config memory bytes only while unlocked
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= `GCP_CFG_RST;
			unlock_q <= `GCP_CFG_RST;
			initial_capacity_byte_q <= `GCP_INITIAL_CAPACITY_BYTE_RST;
			pack_configuration_q <= `GCP_CFG_RST;
			initial_max_load_q <= `GCP_INITIAL_MAX_LOAD_RST;
			discharge_rate_coeffs_q <= `GCP_CFG_RST;
			temperature_coeffs_q <= `GCP_CFG_RST;
			dmfsd_q <= `GCP_DMFSD_RST;
		end else if (reg_wr) begin
			if (reg_addr == `GCP_MODE_OFS) begin
				mode_q <= reg_wdata;
			end else if (reg_addr == `GCP_UNLOCK_OFS) begin
				unlock_q <= reg_wdata;
			end else if (unlocked && reg_addr == `GCP_INITIAL_CAPACITY_BYTE_OFS) begin
				initial_capacity_byte_q <= reg_wdata;
			end else if (unlocked && reg_addr == `GCP_DMFSD_OFS) begin
				dmfsd_q <= reg_wdata;
			end else if (unlocked && reg_addr == `GCP_PACK_CONFIGURATION_OFS) begin
				pack_configuration_q <= reg_wdata;
			end else if (unlocked && reg_addr == `GCP_INITIAL_MAX_LOAD_OFS) begin
				initial_max_load_q <= reg_wdata;
			end else if (unlocked && reg_addr == `GCP_DISCHARGE_RATE_COEFFS_OFS) begin
				discharge_rate_coeffs_q <= reg_wdata;
			end else if (unlocked && reg_addr == `GCP_TEMPERATURE_COEFFS_OFS) begin
				temperature_coeffs_q <= reg_wdata;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Discharge and temperature compensation
	// -------------------------------------------------------------------------
	logic [7:0] discharge_rate_coeffs_eff;
	logic [7:0] temperature_coeffs_eff;
	logic [5:0] discharge_comp_gain;
	logic [1:0] discharge_comp_threshold;
	logic [3:0] temp_comp_gain;
	logic [3:0] temp_comp_offset;
	logic [15:0] full_cap;
	logic [15:0] thr;
	logic [31:0] discharge_compensation_w;
	logic [31:0] excess_w;
	logic [31:0] discharge_compensated_capacity_w;
	logic [31:0] kdiff_w;
	logic [31:0] temperature_compensation_w;
	logic [31:0] temp_compensated_capacity_w;

	assign discharge_rate_coeffs_eff = pack_configuration_q[`GCP_FIXED_DISCHARGE_SELECT_BIT] ? `GCP_DISCHARGE_RATE_COEFFS_FIXED : discharge_rate_coeffs_q;
	assign temperature_coeffs_eff = pack_configuration_q[`GCP_FIXED_TEMPERATURE_SELECT_BIT] ? `GCP_TEMPERATURE_COEFFS_FIXED : temperature_coeffs_q;
	assign discharge_comp_gain = discharge_rate_coeffs_eff[7:2];
	assign discharge_comp_threshold = discharge_rate_coeffs_eff[1:0];
	assign temp_comp_gain = temperature_coeffs_eff[7:4];
	assign temp_comp_offset = temperature_coeffs_eff[3:0];
	assign full_cap = {initial_capacity_byte_q, 8'h00};
	// Threshold select decode
	assign thr = (discharge_comp_threshold == 2'b00) ? 16'h0000 :
		(discharge_comp_threshold == 2'b01) ? {1'b0, full_cap[15:1]} :
		(discharge_comp_threshold == 2'b10) ? {2'b00, full_cap[15:2]} :
		{3'b000, full_cap[15:3]};
	// Gain times excess current over 256, clamped at zero
	assign discharge_compensation_w = (32'(discharge_comp_gain) *
		gcp_clamp_sub(32'(average_current), 32'(thr))) >> 8;
	assign excess_w = gcp_clamp_sub(discharge_compensation_w, 32'(compensation_at_last_learn));
	assign discharge_compensated_capacity_w = gcp_clamp_sub(32'(nominal_available_charge), excess_w);
	// Offset above 273 K, also the cold learning limit
	assign kdiff_w = gcp_clamp_sub(32'(`GCP_KELVIN_BASE) + 32'(temp_comp_offset),
		32'(temp_kelvin));
	assign temperature_compensation_w = (32'(temp_comp_gain) * 32'(initial_capacity_byte_q) * kdiff_w) >> 2;
	assign temp_compensated_capacity_w = gcp_clamp_sub(discharge_compensated_capacity_w, temperature_compensation_w);

	// Results held in flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			discharge_compensated_capacity <= 16'h0000;
			temp_compensated_capacity <= 16'h0000;
		end else begin
			discharge_compensated_capacity <= discharge_compensated_capacity_w[15:0];
			temp_compensated_capacity <= temp_compensated_capacity_w[15:0];
		end
	end

	// -------------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------------
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] pin_q;
	logic line_low;
	logic lines_high;
	logic any_high;
	logic por_ok;
	logic rbi_ok;

	// Three stages from idle levels; a change counts once two and three agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= `GCP_PIN_RST;
			s2_q <= `GCP_PIN_RST;
			s3_q <= `GCP_PIN_RST;
			pin_q <= `GCP_PIN_RST;
		end else begin
			s1_q <= {backup_supply_input, supply_above_por, comm_line};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
		end
	end
	assign line_low = ~&pin_q[1:0];
	assign lines_high = &pin_q[1:0];
	assign any_high = |pin_q[1:0];
	assign por_ok = pin_q[2];
	assign rbi_ok = pin_q[3];

	// -------------------------------------------------------------------------
	// Power mode machine
	// -------------------------------------------------------------------------
	gcp_mode_t mode_st_q;
	gcp_mode_t mode_st_d;
	logic [31:0] low_cnt_q;
	logic [35:0] wake_cnt_q;
	logic ship_cmd;
	logic quiet;
	logic low_done;
	logic wake_due;
	logic rst_pulse_d;

	assign ship_cmd = reg_wr && reg_addr == `GCP_CTRL_OFS && reg_wdata == `GCP_SHIP_CMD &&
		mode_q[`GCP_SHIP_BIT];
	// Zero filter threshold falls back to near-zero average current
	assign quiet = !activity_above_filter && ((dmfsd_q[7:4] != 4'h0) ||
		(average_current < `GCP_SLEEP_CUR_MIN));
	assign low_done = (low_cnt_q >= LOW_HOLD_CYC - 1);
	assign wake_due = (wake_cnt_q >= WAKE_CYC - 1);

	// Next mode
	always_comb begin
		mode_st_d = mode_st_q;
		rst_pulse_d = 1'b0;
		case (mode_st_q)
			GCP_ACTIVE: begin
				if (!por_ok) begin
					mode_st_d = GCP_HIBER;
				end else if (ship_armed_q && low_done && line_low) begin
					mode_st_d = GCP_SHIP;
				end else if (low_done && quiet) begin
					mode_st_d = GCP_SLEEP;
				end
			end
			GCP_SLEEP: begin
				if (!por_ok) begin
					mode_st_d = GCP_HIBER;
				end else if (lines_high || wake_due) begin
					mode_st_d = GCP_ACTIVE;
				end
			end
			GCP_SHIP: begin
				if (!por_ok) begin
					mode_st_d = GCP_HIBER;
				end else if (lines_high) begin
					mode_st_d = GCP_ACTIVE;
					rst_pulse_d = 1'b1;
				end else if (any_high) begin
					mode_st_d = quiet ? GCP_SLEEP : GCP_ACTIVE;
					rst_pulse_d = 1'b1;
				end
			end
			GCP_HIBER: begin
				if (por_ok) begin
					mode_st_d = GCP_ACTIVE;
					rst_pulse_d = !rbi_ok;
				end
			end
			default: begin
				mode_st_d = GCP_ACTIVE;
			end
		endcase
	end

	// Mode register, counters and ship arming
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_st_q <= GCP_ACTIVE;
			low_cnt_q <= 32'h0000_0000;
			wake_cnt_q <= 36'h0_0000_0000;
			ship_armed_q <= 1'b0;
			full_reset_pulse <= 1'b0;
		end else begin
			mode_st_q <= mode_st_d;
			full_reset_pulse <= rst_pulse_d;
			// Armed transients do not restart the count
			if (!line_low && !ship_armed_q) begin
				low_cnt_q <= 32'h0000_0000;
			end else if (mode_st_q != GCP_ACTIVE || mode_st_d != GCP_ACTIVE) begin
				low_cnt_q <= 32'h0000_0000;
			end else if (line_low && !low_done) begin
				low_cnt_q <= low_cnt_q + 32'h0000_0001;
			end
			if (mode_st_q == GCP_SLEEP && !wake_due) begin
				wake_cnt_q <= wake_cnt_q + 36'h0_0000_0001;
			end else begin
				wake_cnt_q <= 36'h0_0000_0000;
			end
			if (ship_cmd) begin
				ship_armed_q <= 1'b1;
			end else if (mode_st_q == GCP_SHIP || rst_pulse_d) begin
				ship_armed_q <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Learned max load
	// -------------------------------------------------------------------------
	// Reload on reset paths, grow on larger current
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			max_load_current <= 16'h0000;
		end else if (full_reset_req || full_reset_pulse) begin
			max_load_current <= {8'h00, initial_max_load_q};
		end else if (mode_st_q == GCP_ACTIVE && average_current > max_load_current) begin
			max_load_current <= average_current;
		end
	end

	assign gauging_enable = (mode_st_q == GCP_ACTIVE);
	assign retain_gauge_ram = rbi_ok;
	assign power_mode = mode_st_q;

	// -------------------------------------------------------------------------
	// Read path
	// -------------------------------------------------------------------------
	logic [7:0] rd_mux;
	assign rd_mux = (reg_addr == `GCP_MODE_OFS) ? mode_q :
		(reg_addr == `GCP_STATUS_OFS) ? {3'b000, ship_armed_q, mode_st_q} :
		(reg_addr == `GCP_CURR_OFS) ? max_load_current[15:8] :
		(reg_addr == `GCP_NAC_OFS) ? discharge_compensated_capacity[15:8] :
		(reg_addr == `GCP_TEMP_COMPENSATED_CAPACITY_OFS) ? temp_compensated_capacity[15:8] :
		(reg_addr == `GCP_MLOAD_OFS) ? max_load_current[7:0] :
		(reg_addr == `GCP_DMFSD_OFS) ? dmfsd_q :
		(reg_addr == `GCP_UNLOCK_OFS) ? unlock_q :
		(reg_addr == `GCP_INITIAL_CAPACITY_BYTE_OFS) ? initial_capacity_byte_q :
		(reg_addr == `GCP_PACK_CONFIGURATION_OFS) ? pack_configuration_q :
		(reg_addr == `GCP_INITIAL_MAX_LOAD_OFS) ? initial_max_load_q :
		(reg_addr == `GCP_DISCHARGE_RATE_COEFFS_OFS) ? discharge_rate_coeffs_q :
		(reg_addr == `GCP_TEMPERATURE_COEFFS_OFS) ? temperature_coeffs_q : 8'h00;

	// Read data valid the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	fix_dis_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		pack_configuration_q[1] |-> discharge_comp_gain == 6'h10 && discharge_comp_threshold == 2'b10)
		else $error("fixed discharge coefficients wrong");
	fix_tmp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		pack_configuration_q[0] |-> temp_comp_gain == 4'h7 && temp_comp_offset == 4'hC)
		else $error("fixed temperature coefficients wrong");
	discharge_compensated_capacity_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		discharge_compensated_capacity <= $past(nominal_available_charge))
		else $error("compensated capacity above nominal");
	temp_compensated_capacity_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		temp_compensated_capacity <= discharge_compensated_capacity || $changed(nominal_available_charge)
		|| $changed(temp_kelvin) || $changed(average_current))
		else $error("temperature capacity above discharge capacity");
	load_reset_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		full_reset_req |=> max_load_current == {8'h00, $past(initial_max_load_q)})
		else $error("max load not reloaded");
	sleep_wake_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode_st_q == GCP_SLEEP && lines_high && por_ok |=> mode_st_q == GCP_ACTIVE)
		else $error("sleep not left on high lines");
	ship_exit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode_st_q == GCP_SHIP && por_ok && any_high |=> full_reset_pulse)
		else $error("ship exit without full reset");
	hiber_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		!por_ok |=> mode_st_q == GCP_HIBER)
		else $error("hibernate not entered");
endmodule : gcp_core

// file: rtl/gcp_map.svh
// Purpose: Offsets, fields, reset values and timing counts of the gauge block
// Assumes: 20 MHz core clock, register port with 7-bit addresses
// Notes: Included by the core module and the testbench
`ifndef GCP_MAP_SVH
`define GCP_MAP_SVH
// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define GCP_CTRL_OFS 7'h00
`define GCP_MODE_OFS 7'h01
`define GCP_STATUS_OFS 7'h02
`define GCP_CURR_OFS 7'h03
`define GCP_TEMP_OFS 7'h04
`define GCP_NAC_OFS 7'h05
`define GCP_MLOAD_OFS 7'h06
`define GCP_TEMP_COMPENSATED_CAPACITY_OFS 7'h07
`define GCP_DMFSD_OFS 7'h08
`define GCP_UNLOCK_OFS 7'h6E
`define GCP_INITIAL_CAPACITY_BYTE_OFS 7'h76
`define GCP_PACK_CONFIGURATION_OFS 7'h7C
`define GCP_INITIAL_MAX_LOAD_OFS 7'h7D
`define GCP_DISCHARGE_RATE_COEFFS_OFS 7'h7E
`define GCP_TEMPERATURE_COEFFS_OFS 7'h7F
// -----------------------------------------------------------------------------
// Field positions and command values
// -----------------------------------------------------------------------------
`define GCP_SHIP_BIT 5
`define GCP_FIXED_DISCHARGE_SELECT_BIT 1
`define GCP_FIXED_TEMPERATURE_SELECT_BIT 0
`define GCP_SHIP_CMD 8'hA9
`define GCP_UNLOCK_KEY 8'hDD
`define GCP_DISCHARGE_RATE_COEFFS_FIXED 8'h42
`define GCP_TEMPERATURE_COEFFS_FIXED 8'h7C
`define GCP_KELVIN_BASE 16'd273
`define GCP_SLEEP_CUR_MIN 16'h0001
// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define GCP_CFG_RST 8'h00
`define GCP_INITIAL_MAX_LOAD_RST 8'h00
`define GCP_INITIAL_CAPACITY_BYTE_RST 8'h00
`define GCP_DMFSD_RST 8'h00
`define GCP_PIN_RST 4'hF
// -----------------------------------------------------------------------------
// Timing: 18 s line-low hold, 43.6 min periodic wake, 20 MHz clock
// -----------------------------------------------------------------------------
`define GCP_CLK_HZ 20000000
`define GCP_LOW_HOLD_MS 18000
`define GCP_WAKE_PERIOD_DS 26160
`define GCP_LOW_HOLD_CYC (`GCP_CLK_HZ / 1000 * `GCP_LOW_HOLD_MS)
`define GCP_WAKE_CYC (64'(`GCP_CLK_HZ) / 64'd10 * 64'(`GCP_WAKE_PERIOD_DS))
`endif

// file: rtl/gcp_pkg.sv
// Purpose: Types shared by the gauge block
// Assumes: Nothing beyond the map header
// Notes: Power mode states are one-hot
package gcp_pkg;
	typedef enum logic [3:0] {
		GCP_ACTIVE = 4'h1,
		GCP_SLEEP = 4'h2,
		GCP_SHIP = 4'h4,
		GCP_HIBER = 4'h8
	} gcp_mode_t;
endpackage : gcp_pkg

// file: test/gcp_host_model.sv
// Purpose: Host side of the two communication lines
// Assumes: Device pulls released lines low
// Notes: Host only drives high; a released line reads low
`timescale 1ns/1ns
module gcp_host_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [1:0] line_high,
	output logic [1:0] comm_line
);
	// Drive requested lines high, release the rest to the pull-down
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			comm_line <= 2'h3;
		end else begin
			comm_line <= line_high;
		end
	end
endmodule : gcp_host_model

// file: test/tb_top.sv
// Purpose: Self-checking bench for compensation, power modes and unlock
// Assumes: Shortened hold and wake counts
// Notes: Expected capacities are computed here from the coefficient bytes
`timescale 1ns/1ns
`include "gcp_map.svh"
module tb_top import gcp_pkg::*; ;
	localparam int HOLD = 20;
	localparam int WAKE = 50;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] line_high = 2'h3;
	logic [1:0] comm_line;
	logic supply_above_por = 1'b1;
	logic backup_supply_input = 1'b1;
	logic [15:0] average_current = 16'h0000;
	logic [15:0] temp_kelvin = 16'h0000;
	logic [15:0] nominal_available_charge = 16'h0000;
	logic [15:0] compensation_at_last_learn = 16'h0000;
	logic activity_above_filter = 1'b0;
	logic full_reset_req = 1'b0;
	logic [15:0] max_load_current, discharge_compensated_capacity, temp_compensated_capacity;
	logic gauging_enable, full_reset_pulse, retain_gauge_ram, program_unlocked;
	logic [3:0] power_mode;
	logic [7:0] rd_q;
	logic seen_reset = 1'b0;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;

	gcp_host_model gcp_host_model_inst (.core_clk(core_clk), .rst_b(rst_b),
		.line_high(line_high), .comm_line(comm_line));
	gcp_core #(.LOW_HOLD_CYC(HOLD), .WAKE_CYC(WAKE)) gcp_core_inst (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comm_line(comm_line),
		.supply_above_por(supply_above_por), .backup_supply_input(backup_supply_input),
		.average_current(average_current), .temp_kelvin(temp_kelvin),
		.nominal_available_charge(nominal_available_charge),
		.compensation_at_last_learn(compensation_at_last_learn),
		.activity_above_filter(activity_above_filter), .full_reset_req(full_reset_req),
		.max_load_current(max_load_current),
		.discharge_compensated_capacity(discharge_compensated_capacity),
		.temp_compensated_capacity(temp_compensated_capacity),
		.gauging_enable(gauging_enable), .full_reset_pulse(full_reset_pulse),
		.retain_gauge_ram(retain_gauge_ram), .program_unlocked(program_unlocked),
		.power_mode(power_mode));

	// ---------------------------------------------------------------------
	// Clock, watchdog, full-reset pulse catcher
	// ---------------------------------------------------------------------
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (full_reset_pulse === 1'b1) seen_reset <= 1'b1;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end

	// ---------------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------------
	task automatic close_out();
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rd_q = reg_rdata;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic wait_mode(input logic [3:0] m, input int lim);
		for (int i = 0; i < lim && power_mode !== m; i++) cyc(1);
	endtask : wait_mode
	// Expected compensated capacities, negative terms clamped to zero
	function automatic logic [15:0] temp_compensated_capacity_exp(input logic [7:0] dc, input logic [7:0] tc,
		input logic [15:0] ai, input logic [15:0] lc, input logic [15:0] t,
		output logic [15:0] cd);
		logic [31:0] thr, dm, tm, tb;
		thr = (dc[1:0] == 2'h0) ? 32'h0 : (32'h1000 >> dc[1:0]);
		dm = (ai > thr) ? (dc[7:2] * (ai - thr)) / 256 : 32'h0;
		cd = (dm > lc) ? 16'h8000 - 16'(dm - lc) : 16'h8000;
		tb = 273 + tc[3:0];
		tm = (tb > t) ? (tc[7:4] * 32'h10 * (tb - t)) / 4 : 32'h0;
		return cd - 16'(tm);
	endfunction : temp_compensated_capacity_exp

	// ---------------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------------
	initial begin
		logic [7:0] dc;
		logic [15:0] cd, ct, lc, tk;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		cyc(2);
		chk("mode_rst", 16'(power_mode), 16'(GCP_ACTIVE));
		chk("gauge_rst", 16'(gauging_enable), 16'h0001);
		chk("mload_rst", max_load_current, 16'h0000);
		// Config bytes refused while locked, unmapped reads zero
		wr(`GCP_INITIAL_MAX_LOAD_OFS, 8'h55);
		rd(`GCP_INITIAL_MAX_LOAD_OFS);
		chk("initial_max_load_locked", 16'(rd_q), 16'h0000);
		rd(7'h40);
		chk("unmapped", 16'(rd_q), 16'h0000);
		wr(`GCP_UNLOCK_OFS, `GCP_UNLOCK_KEY);
		cyc(1);
		chk("unlocked", 16'(program_unlocked), 16'h0001);
		wr(`GCP_INITIAL_CAPACITY_BYTE_OFS, 8'h10);
		rd(`GCP_INITIAL_CAPACITY_BYTE_OFS);
		chk("initial_capacity_byte_rb", 16'(rd_q), 16'h0010);
		wr(`GCP_INITIAL_MAX_LOAD_OFS, 8'h20);
		rd(`GCP_INITIAL_MAX_LOAD_OFS);
		chk("initial_max_load_rb", 16'(rd_q), 16'h0020);
		// Every threshold select, clamp cases, then fixed coefficients
		for (int k = 0; k < 6; k++) begin
			dc = (k < 4) ? 8'(8'h40 + k) : 8'h40;
			lc = (k == 4) ? 16'h0400 : 16'h0100;
			tk = (k == 4) ? 16'd300 : 16'd270;
			wr(`GCP_DISCHARGE_RATE_COEFFS_OFS, dc);
			wr(`GCP_TEMPERATURE_COEFFS_OFS, 8'h24);
			if (k == 5) wr(`GCP_PACK_CONFIGURATION_OFS, 8'h03);
			rd(`GCP_DISCHARGE_RATE_COEFFS_OFS);
			chk("discharge_rate_coeffs_rb", 16'(rd_q), 16'(dc));
			@(posedge core_clk);
			average_current <= 16'h3000;
			nominal_available_charge <= 16'h8000;
			compensation_at_last_learn <= lc;
			temp_kelvin <= tk;
			cyc(4);
			ct = temp_compensated_capacity_exp((k == 5) ? 8'h42 : dc, (k == 5) ? 8'h7C : 8'h24, 16'h3000, lc, tk, cd);
			chk("discharge_compensated_capacity", discharge_compensated_capacity, cd);
			chk("temp_compensated_capacity", temp_compensated_capacity, ct);
		end
		chk("mload_learn", max_load_current, 16'h3000);
		@(posedge core_clk);
		average_current <= 16'h0010;
		full_reset_req <= 1'b1;
		@(posedge core_clk);
		full_reset_req <= 1'b0;
		cyc(3);
		chk("mload_reload", max_load_current, 16'h0020);
		// Zero filter byte: no sleep while average current is not near zero
		line_high <= 2'h0;
		cyc(HOLD + 10);
		chk("no_sleep", 16'(power_mode), 16'(GCP_ACTIVE));
		@(posedge core_clk);
		average_current <= 16'h0000;
		wait_mode(GCP_SLEEP, HOLD + 10);
		chk("sleep", 16'(power_mode), 16'(GCP_SLEEP));
		chk("gauge_off", 16'(gauging_enable), 16'h0000);
		wait_mode(GCP_ACTIVE, WAKE + 10);
		chk("wake", 16'(power_mode), 16'(GCP_ACTIVE));
		@(posedge core_clk);
		activity_above_filter <= 1'b1;
		cyc(HOLD + 10);
		chk("stay_busy", 16'(power_mode), 16'(GCP_ACTIVE));
		@(posedge core_clk);
		activity_above_filter <= 1'b0;
		wait_mode(GCP_SLEEP, HOLD + 10);
		chk("resleep", 16'(power_mode), 16'(GCP_SLEEP));
		line_high <= 2'h3;
		wait_mode(GCP_ACTIVE, 8);
		chk("lines_high", 16'(power_mode), 16'(GCP_ACTIVE));
		// Ship: arm, transient before entry, leave by one-line blip or all high
		for (int k = 0; k < 2; k++) begin
			line_high <= 2'h3;
			wr(`GCP_MODE_OFS, 8'h20);
			wr(`GCP_CTRL_OFS, `GCP_SHIP_CMD);
			rd(`GCP_STATUS_OFS);
			chk("armed", 16'(rd_q[4]), 16'h0001);
			line_high <= 2'h0;
			cyc(12);
			line_high <= 2'h3;
			cyc(4);
			line_high <= 2'h0;
			wait_mode(GCP_SHIP, HOLD);
			chk("ship", 16'(power_mode), 16'(GCP_SHIP));
			seen_reset <= 1'b0;
			line_high <= (k == 1) ? 2'h3 : 2'h2;
			cyc(6);
			if (k == 0) line_high <= 2'h0;
			wait_mode((k == 1) ? GCP_ACTIVE : GCP_SLEEP, HOLD + 10);
			cyc(2);
			chk("ship_exit", 16'(power_mode), (k == 1) ? 16'h0001 : 16'h0002);
			chk("ship_reset", 16'(seen_reset), 16'h0001);
		end
		// Hibernate with backup held, then with backup lost
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			backup_supply_input <= (k == 0);
			supply_above_por <= 1'b0;
			wait_mode(GCP_HIBER, 10);
			chk("hiber", 16'(power_mode), 16'(GCP_HIBER));
			chk("retain", 16'(retain_gauge_ram), 16'(k == 0));
			@(posedge core_clk);
			seen_reset <= 1'b0;
			supply_above_por <= 1'b1;
			wait_mode(GCP_ACTIVE, 10);
			cyc(4);
			chk("hiber_exit", 16'(power_mode), 16'(GCP_ACTIVE));
			chk("hiber_reset", 16'(seen_reset), 16'(k == 1));
		end
		close_out();
	end
endmodule : tb_top
